/* inc/flash_status_pkg.sv */
// constants and types for the serial flash status register logic
// Behaviour
// - lock bit and low pin freeze register writes
// - pin high or lock clear allows writes
// - program error set by failure or protection
// - erase error set by failure or protection
// - whole-array erase sets erase error only on failure, never on protection
// - clear-status command zeroes both error flags
// - protect bits volatile per config, default ones
// - any protect bit refuses protected area
// - whole-array erase only with protect bits zero
// - write-enable command sets the latch
// - write-disable command clears the latch
// - latch clear ignores writes, programs, erases
// - successful operation clears the latch
// - resets clear latch; register write clears it too
// - busy accepts only reads, suspends, clear, reset
// - suspends accepted only during matching operation
// - error keeps busy until clear-status or soft reset
// - status read returns byte, register write loads
// - volatile bits take defaults on every reset
package flash_status_pkg;
	// command codes
	localparam logic [7:0] REGISTER_WRITE_CMD = 8'h01;
	localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
	localparam logic [7:0] STATUS_READ_CMD = 8'h05;
	localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] CLEAR_STATUS_CMD = 8'h30;
	// codes below are plain defaults
	localparam logic [7:0] STATUS_TWO_READ_CMD = 8'h07;
	localparam logic [7:0] PROGRAM_CMD = 8'h02;
	localparam logic [7:0] SECTOR_ERASE_CMD = 8'hD8;
	localparam logic [7:0] WHOLE_ARRAY_ERASE_CMD = 8'hC7;
	localparam logic [7:0] ERASE_SUSPEND_CMD = 8'h75;
	localparam logic [7:0] PROGRAM_SUSPEND_CMD = 8'h85;
	localparam logic [7:0] SOFT_RESET_CMD = 8'hF0;
	// status_one field positions
	localparam int LOCK_BIT = 7;
	localparam int PERR_BIT = 6;
	localparam int EERR_BIT = 5;
	localparam int PROT_HI = 4;
	localparam int PROT_LO = 2;
	localparam int WEL_BIT = 1;
	localparam int BUSY_BIT = 0;
	// reset and default values
	localparam logic [2:0] PROTECT_VOLATILE_DEFAULT = 3'h7;
	localparam logic [2:0] PROTECT_CLEAR = 3'h0;
	localparam logic [7:0] STATUS_TWO_VALUE = 8'h00;
	// one registered event set from the serial link
	typedef struct packed {
		logic start;
		logic byte_ok;
		logic stop;
		logic [7:0] data;
	} link_event_type;
	// completion report from the array engine
	typedef struct packed {
		logic done;
		logic fail;
		logic prot_fail;
	} op_result_type;
	typedef enum logic [1:0] {
		OP_PROGRAM = 2'b00,
		OP_SECTOR_ERASE = 2'b01,
		OP_WHOLE_ERASE = 2'b10,
		OP_NONE = 2'b11
	} op_kind_type;
	typedef enum logic [2:0] {
		FR_CMD = 3'b000,
		FR_STAT1 = 3'b001,
		FR_STAT2 = 3'b010,
		FR_WRREG = 3'b011,
		FR_WRDONE = 3'b100,
		FR_ARRAY = 3'b101,
		FR_SKIP = 3'b110
	} frame_state_type;
endpackage

/* src/spi_link.sv */
// serial link front end: pin synchronisers, byte shifter, status shifter
`timescale 1ns/1ps
`default_nettype none
module spi_link (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// pins from the host
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	// byte to send and link events
	input wire logic [7:0] tx_byte,
	output flash_status_pkg::link_event_type ev,
	output logic miso
);
	import flash_status_pkg::*;
	logic sck_m, sck_s, sck_d, cs_m, cs_s, cs_d, mosi_m, mosi_s;
	logic [2:0] cnt_r;
	logic [7:0] rx_r, tx_r;
	logic rise, fall;

	// two synchroniser flops per pin plus an edge flop on sck and cs_n; only the second stage and later are looked at
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			{sck_m, sck_s, sck_d} <= 3'h0;
			{cs_m, cs_s, cs_d} <= 3'h7;
			{mosi_m, mosi_s} <= 2'h0;
		end else begin
			{sck_m, sck_s, sck_d} <= {sck, sck_m, sck_s};
			{cs_m, cs_s, cs_d} <= {cs_n, cs_m, cs_s};
			{mosi_m, mosi_s} <= {mosi, mosi_m};
		end
	end

	// mosi is delayed like sck, so it is sampled at the true rising edge
	assign rise = sck_s & ~sck_d & ~cs_s;
	assign fall = ~sck_s & sck_d & ~cs_s;

	// receive shifter, msb first
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_r <= 3'h0;
			rx_r <= 8'h00;
		end else if (cs_d & ~cs_s) begin
			cnt_r <= 3'h0;
		end else if (rise) begin
			rx_r <= {rx_r[6:0], mosi_s};
			cnt_r <= cnt_r + 3'd1;
		end
	end

	// events are one-cycle pulses
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ev <= '0;
		end else begin
			ev.start <= cs_d & ~cs_s;
			ev.stop <= ~cs_d & cs_s;
			ev.byte_ok <= rise & (cnt_r == 3'd7);
			if (rise & (cnt_r == 3'd7)) begin
				ev.data <= {rx_r[6:0], mosi_s};
			end
		end
	end

	// transmit on falling edges; a fresh byte is taken at every byte boundary
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			miso <= 1'b0;
			tx_r <= 8'h00;
		end else if (fall) begin
			if (cnt_r == 3'd0) begin
				miso <= tx_byte[7];
				tx_r <= {tx_byte[6:0], 1'b0};
			end else begin
				miso <= tx_r[7];
				tx_r <= {tx_r[6:0], 1'b0};
			end
		end
	end

	a_byte_after_eight: assert property (@(posedge mclk) disable iff (rst)
		ev.byte_ok |-> $past(cnt_r) == 3'd7)
		else $error("byte event without eight bits");
endmodule
`default_nettype wire

/* src/flash_status_register_logic.sv */
// status register, write-enable latch, busy and error flags of a serial flash
`timescale 1ns/1ps
`default_nettype none
module flash_status_register_logic (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// serial link pins
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	// hardware write protect pin, low protects
	input wire logic write_protect_n,
	// configuration bit and non-volatile copy of lock and protect bits
	input wire logic protect_volatility_bit,
	input wire logic [7:0] nv_status,
	output logic nv_write,
	output logic [7:0] nv_data,
	// array engine
	output logic op_start,
	output flash_status_pkg::op_kind_type op_kind,
	input wire flash_status_pkg::op_result_type op_res,
	input wire logic area_protected,
	output logic erase_suspend,
	output logic program_suspend,
	// status view
	output logic [7:0] status_one
);
	import flash_status_pkg::*;
	link_event_type ev;
	frame_state_type state_r;
	op_kind_type kind_r, req_kind;
	logic [7:0] tx_byte, cmd_r, wr_data_r;
	logic [2:0] bp_r;
	logic wp_m, wp_s, init_r;
	logic lock_r, perr_r, eerr_r, wel_r, busy_r, running_r;
	logic hw_locked, accept, single, do_write_enable_cmd, do_write_disable_cmd, do_clear_status_cmd, do_srst;
	logic wrreg_try, do_wrreg, array_try, whole_refused, prot_hit, start_ok;
	logic done_ok, fail_now, perr_set, eerr_set, err_set;

	spi_link u_link (
		.mclk(mclk),
		.rst(rst),
		.sck(sck),
		.cs_n(cs_n),
		.mosi(mosi),
		.tx_byte(tx_byte),
		.ev(ev),
		.miso(miso)
	);

	// commands that a busy device still takes
	function automatic logic busy_ok(input logic [7:0] c);
		busy_ok = (c == STATUS_READ_CMD) || (c == STATUS_TWO_READ_CMD) ||
			(c == ERASE_SUSPEND_CMD) || (c == PROGRAM_SUSPEND_CMD) ||
			(c == CLEAR_STATUS_CMD) || (c == SOFT_RESET_CMD);
	endfunction

	// frame state chosen by the opcode byte
	function automatic frame_state_type cmd_state(input logic [7:0] c);
		case (c)
			STATUS_READ_CMD: cmd_state = FR_STAT1;
			STATUS_TWO_READ_CMD: cmd_state = FR_STAT2;
			REGISTER_WRITE_CMD: cmd_state = FR_WRREG;
			PROGRAM_CMD, SECTOR_ERASE_CMD, WHOLE_ARRAY_ERASE_CMD: cmd_state = FR_ARRAY;
			default: cmd_state = FR_SKIP;
		endcase
	endfunction

	// write protect pin comes from outside, two flops
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wp_m <= 1'b1;
			wp_s <= 1'b1;
		end else begin
			wp_m <= write_protect_n;
			wp_s <= wp_m;
		end
	end

	// one cycle after reset release the stored bits are fetched
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			init_r <= 1'b1;
		end else begin
			init_r <= 1'b0;
		end
	end

	// frame tracking; trailing bytes of long commands are ignored here
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r <= FR_SKIP;
			cmd_r <= 8'h00;
			wr_data_r <= 8'h00;
		end else if (ev.start) begin
			state_r <= FR_CMD;
		end else if (ev.byte_ok) begin
			case (state_r)
				FR_CMD: begin
					cmd_r <= ev.data;
					state_r <= cmd_state(ev.data);
				end
				FR_WRREG: begin
					wr_data_r <= ev.data;
					state_r <= FR_WRDONE;
				end
				default: state_r <= state_r;
			endcase
		end
	end

	// commands execute when chip select rises, so a cut-short frame does nothing
	assign hw_locked = lock_r & ~wp_s;
	assign accept = ev.stop & (~busy_r | busy_ok(cmd_r));
	assign single = accept & (state_r == FR_SKIP);
	assign do_write_enable_cmd = single & (cmd_r == WRITE_ENABLE_CMD);
	assign do_write_disable_cmd = single & (cmd_r == WRITE_DISABLE_CMD);
	assign do_clear_status_cmd = single & (cmd_r == CLEAR_STATUS_CMD);
	assign do_srst = single & (cmd_r == SOFT_RESET_CMD);
	assign wrreg_try = accept & (state_r == FR_WRDONE) & wel_r;
	assign do_wrreg = wrreg_try & ~hw_locked;
	assign array_try = accept & (state_r == FR_ARRAY) & wel_r;
	assign req_kind = (cmd_r == PROGRAM_CMD) ? OP_PROGRAM :
		(cmd_r == SECTOR_ERASE_CMD) ? OP_SECTOR_ERASE : OP_WHOLE_ERASE;
	assign whole_refused = (req_kind == OP_WHOLE_ERASE) & (bp_r != PROTECT_CLEAR);
	assign prot_hit = (req_kind != OP_WHOLE_ERASE) & area_protected;
	assign start_ok = array_try & ~whole_refused & ~prot_hit;

	// completion; a protected sector met by a whole-array erase is not an error
	assign done_ok = op_res.done & running_r;
	assign fail_now = done_ok & (op_res.fail | (op_res.prot_fail & (kind_r != OP_WHOLE_ERASE)));
	assign perr_set = (fail_now & (kind_r == OP_PROGRAM)) |
		(array_try & prot_hit & (req_kind == OP_PROGRAM));
	assign eerr_set = (fail_now & (kind_r != OP_PROGRAM)) |
		(array_try & prot_hit & (req_kind == OP_SECTOR_ERASE));
	assign err_set = perr_set | eerr_set;

	// error flags: a new error wins over a clear in the same cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			perr_r <= 1'b0;
			eerr_r <= 1'b0;
		end else begin
			perr_r <= perr_set | (perr_r & ~do_clear_status_cmd & ~do_srst);
			eerr_r <= eerr_set | (eerr_r & ~do_clear_status_cmd & ~do_srst);
		end
	end

	// busy stays up after an error so the host must see and clear it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			busy_r <= 1'b0;
		end else if (do_srst) begin
			busy_r <= 1'b0;
		end else if (err_set | start_ok) begin
			busy_r <= 1'b1;
		end else if (done_ok) begin
			busy_r <= 1'b0;
		end else if (do_clear_status_cmd & (perr_r | eerr_r)) begin
			busy_r <= 1'b0;
		end
	end

	// running operation and its kind, for suspends and completion
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			running_r <= 1'b0;
			kind_r <= OP_NONE;
		end else if (do_srst | done_ok) begin
			running_r <= 1'b0;
		end else if (start_ok) begin
			running_r <= 1'b1;
			kind_r <= req_kind;
		end
	end

	// write-enable latch; the register write itself never loads it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wel_r <= 1'b0;
		end else if (do_srst) begin
			wel_r <= 1'b0;
		end else if (do_write_enable_cmd) begin
			wel_r <= 1'b1;
		end else if (do_write_disable_cmd) begin
			wel_r <= 1'b0;
		end else if ((done_ok & ~fail_now) | do_wrreg) begin
			wel_r <= 1'b0;
		end
	end

	// lock and protect bits; volatile protect bits fall back to all ones
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			lock_r <= 1'b0;
			bp_r <= PROTECT_CLEAR;
		end else if (init_r) begin
			lock_r <= nv_status[LOCK_BIT];
			bp_r <= protect_volatility_bit ? PROTECT_VOLATILE_DEFAULT : nv_status[PROT_HI:PROT_LO];
		end else if (do_wrreg) begin
			lock_r <= wr_data_r[LOCK_BIT];
			bp_r <= wr_data_r[PROT_HI:PROT_LO];
		end else if (do_srst & protect_volatility_bit) begin
			bp_r <= PROTECT_VOLATILE_DEFAULT;
		end
	end

	// non-volatile store update; error, latch and busy bits are never stored
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			nv_write <= 1'b0;
			nv_data <= 8'h00;
		end else begin
			nv_write <= do_wrreg;
			if (do_wrreg) begin
				nv_data <= {wr_data_r[LOCK_BIT], 2'b00, wr_data_r[PROT_HI:PROT_LO], 2'b00};
			end
		end
	end

	// array engine requests and suspends
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			op_start <= 1'b0;
			op_kind <= OP_NONE;
			erase_suspend <= 1'b0;
			program_suspend <= 1'b0;
		end else begin
			op_start <= start_ok;
			if (start_ok) begin
				op_kind <= req_kind;
			end
			erase_suspend <= single & (cmd_r == ERASE_SUSPEND_CMD) & running_r & (kind_r != OP_PROGRAM);
			program_suspend <= single & (cmd_r == PROGRAM_SUSPEND_CMD) & running_r & (kind_r == OP_PROGRAM);
		end
	end

	// status byte built from the flag flops
	assign status_one = {lock_r, perr_r, eerr_r, bp_r, wel_r, busy_r};

	// byte handed to the shifter at each boundary; live value every repeat
	always_comb begin
		case (state_r)
			FR_STAT1: tx_byte = status_one;
			FR_STAT2: tx_byte = STATUS_TWO_VALUE;
			default: tx_byte = 8'h00;
		endcase
	end

	// drive miso only during the data phase of a status read
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			miso_oe <= 1'b0;
		end else if (ev.start | ev.stop) begin
			miso_oe <= 1'b0;
		end else if (ev.byte_ok & (state_r == FR_CMD)) begin
			miso_oe <= (ev.data == STATUS_READ_CMD) | (ev.data == STATUS_TWO_READ_CMD);
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// checks that travel with the logic they guard
	a_lock_hold: assert property (
		wrreg_try && hw_locked && !init_r |=> $stable(lock_r) && $stable(bp_r))
		else $error("locked register write changed bits");
	a_wrreg_load: assert property (
		do_wrreg && !init_r |=> lock_r == $past(wr_data_r[7]) && bp_r == $past(wr_data_r[4:2]))
		else $error("register write did not load");
	a_perr_readonly: assert property (
		do_wrreg |=> perr_r == $past(perr_r) && eerr_r == $past(eerr_r))
		else $error("register write touched error flags");
	a_whole_no_eerr: assert property (
		done_ok && kind_r == OP_WHOLE_ERASE && !op_res.fail && !eerr_r |=> !eerr_r)
		else $error("whole erase set erase error on protection");
	a_clear_errs: assert property (
		do_clear_status_cmd && !err_set |=> !perr_r && !eerr_r)
		else $error("clear status left an error flag");
	a_protect_gate: assert property (
		op_start && op_kind != OP_WHOLE_ERASE |-> !$past(area_protected))
		else $error("operation started on protected area");
	a_whole_gate: assert property (
		op_start && op_kind == OP_WHOLE_ERASE |-> $past(bp_r) == PROTECT_CLEAR)
		else $error("whole erase with protect bits set");
	a_wel_set: assert property (
		do_write_enable_cmd |=> wel_r)
		else $error("write enable did not set latch");
	a_wel_clear: assert property (
		do_write_disable_cmd |=> !wel_r)
		else $error("write disable did not clear latch");
	a_wel_gate: assert property (
		op_start || nv_write |-> $past(wel_r))
		else $error("write accepted without latch");
	a_wel_auto: assert property (
		done_ok && !fail_now && !do_srst |=> !wel_r && !busy_r)
		else $error("completion left latch or busy set");
	a_busy_filter: assert property (
		busy_r && ev.stop && state_r == FR_SKIP && cmd_r == WRITE_DISABLE_CMD && !done_ok |=> $stable(wel_r))
		else $error("write disable taken while busy");
	a_suspend_gate: assert property (
		erase_suspend |-> $past(running_r && kind_r != OP_PROGRAM))
		else $error("erase suspend without running erase");
	a_busy_sticky: assert property (
		(perr_r || eerr_r) && busy_r && !do_clear_status_cmd && !do_srst |=> busy_r)
		else $error("busy fell while an error was pending");
	a_wel_reset: assert property (
		init_r |-> !wel_r && !busy_r)
		else $error("latch or busy set after reset");
	a_srst_clear: assert property (
		do_srst && !err_set |=> !wel_r && !busy_r && !perr_r && !eerr_r)
		else $error("software reset left a flag set");
	a_err_busy: assert property (
		err_set && !do_srst |=> busy_r)
		else $error("error flag set without busy");
	a_clear_status_cmd_ready: assert property (
		do_clear_status_cmd && (perr_r || eerr_r) && !err_set |=> !busy_r)
		else $error("clear status left device busy");
	a_whole_refused: assert property (
		array_try && req_kind == OP_WHOLE_ERASE && bp_r != PROTECT_CLEAR |=> !op_start && !busy_r)
		else $error("whole erase ran with protect bits set");
	a_prot_error: assert property (
		array_try && prot_hit |=> (perr_r || eerr_r) && busy_r && !op_start)
		else $error("protected operation not refused");
	a_nv_image: assert property (
		nv_write |-> nv_data == {lock_r, 2'b00, bp_r, 2'b00})
		else $error("stored image differs from register");
	a_busy_array: assert property (
		busy_r && ev.stop && state_r == FR_ARRAY |=> !op_start)
		else $error("array command taken while busy");

	// main scenarios the bench should reach
	c_status_read: cover property (miso_oe && state_r == FR_STAT1 ##[1:400] ev.stop);
	c_erase_suspend: cover property (erase_suspend);
	c_reg_write: cover property (do_wrreg);
	c_fail_clear: cover property (fail_now ##[1:1000] do_clear_status_cmd);
	c_locked_write: cover property (wrreg_try && hw_locked);
endmodule
`default_nettype wire

/* verif/spi_host_model.sv */
// host side model of the serial link: mode 0 frames, msb first
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	// serial pins
	output logic sck,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	// idle state: deselected, clock low
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// one frame of nb bytes from the top of tx; clock stands still outside it
	task automatic frame(input logic [23:0] tx, input int nb, output logic [23:0] rx);
		rx = '0;
		cs_n = 1'b0;
		for (int i = 0; i < nb * 8; i++) begin
			mosi = tx[23 - i];
			#200;
			sck = 1'b1;
			rx = {rx[22:0], miso};
			#200;
			sck = 1'b0;
		end
		#200;
		cs_n = 1'b1;
		// a released line shows the inverse, so a stale value cannot pass
		mosi = ~mosi;
		#400;
	endtask
endmodule
`default_nettype wire

/* verif/flash_status_register_logic_bench.sv */
// self-checking bench for the flash status register logic
`timescale 1ns/1ps
`default_nettype none
module flash_status_register_logic_bench;
	import flash_status_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic sck, cs_n, mosi, miso, miso_oe, nv_write, op_start, erase_suspend, program_suspend;
	logic miso_line;
	logic write_protect_n = 1'b1;
	logic protect_volatility_bit = 1'b1;
	logic area_protected = 1'b0;
	logic [7:0] nv_status = 8'h00;
	logic [7:0] nv_data, status_one;
	op_kind_type op_kind;
	op_result_type op_res = '0;
	int num_errors = 0;
	int checks = 0;
	int dly = 4;
	int cnt = 0;
	int nvw = 0;
	int sp = 0;
	int se = 0;
	logic fl = 1'b0;
	logic pf = 1'b0;
	logic [23:0] rx;
	// row: command, data byte, flags {prot_fail, two bytes, wp_n, area protected, fail}, status after
	logic [31:0] rows [0:28] = '{
		32'h0600041E,
		32'h0400041C,
		32'h01000C1C,
		32'h0600041E,
		32'h01800C80,
		32'h06000482,
		32'h011C0882,
		32'h011C0C1C,
		32'h0600041E,
		32'h01000C00,
		32'h06000402,
		32'h02000400,
		32'h06000402,
		32'hC7000400,
		32'h06000402,
		32'hD8000623,
		32'h04000423,
		32'h30000402,
		32'h04000400,
		32'h06000402,
		32'h02000543,
		32'h30000402,
		32'h04000400,
		32'h06000402,
		32'hC7001400,
		32'h06000402,
		32'h01040C04,
		32'h06000406,
		32'hC7000406
	};

	// clock at 20 MHz
	always #25 mclk = ~mclk;

	// a released miso shows the inverse, so a missing enable cannot pass
	assign miso_line = miso_oe ? miso : ~miso;

	spi_host_model host (
		.sck(sck),
		.cs_n(cs_n),
		.mosi(mosi),
		.miso(miso_line)
	);

	flash_status_register_logic uut (
		.mclk(mclk),
		.rst(rst),
		.sck(sck),
		.cs_n(cs_n),
		.mosi(mosi),
		.miso(miso),
		.miso_oe(miso_oe),
		.write_protect_n(write_protect_n),
		.protect_volatility_bit(protect_volatility_bit),
		.nv_status(nv_status),
		.nv_write(nv_write),
		.nv_data(nv_data),
		.op_start(op_start),
		.op_kind(op_kind),
		.op_res(op_res),
		.area_protected(area_protected),
		.erase_suspend(erase_suspend),
		.program_suspend(program_suspend),
		.status_one(status_one)
	);

	// array engine stand-in: done pulse dly cycles after start, never without one
	always @(negedge mclk) begin
		if (op_start) begin
			cnt <= dly;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
		op_res <= (cnt == 1 && !op_start) ? {1'b1, fl, pf} : 3'h0;
	end

	// pulse counters for one-cycle outputs
	always @(posedge mclk) begin
		if (nv_write === 1'b1) nvw++;
		if (program_suspend === 1'b1) sp++;
		if (erase_suspend === 1'b1) se++;
	end

	task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
		checks++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", nm, exp, got);
			num_errors++;
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// send one command frame and let it take effect
	task automatic cmd(input logic [23:0] tx, input int nb);
		host.frame(tx, nb, rx);
		repeat (20) @(negedge mclk);
	endtask

	// bounded wait for the busy flag to fall
	task automatic wait_idle;
		int k;
		for (k = 0; k < 600 && status_one[0] !== 1'b0; k++) @(negedge mclk);
		if (k == 600) begin
			$display("BAD busy_flag expected 0 seen 1");
			num_errors++;
			wrap_up();
		end
		repeat (2) @(negedge mclk);
	endtask

	// hang guard
	initial begin
		repeat (100000) @(posedge mclk);
		num_errors++;
		wrap_up();
	end

	initial begin
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		repeat (3) @(negedge mclk);
		chk("status after reset", 24'h00001C, {16'h0, status_one});
		// table of ordinary commands
		for (int i = 0; i < 29; i++) begin
			@(negedge mclk);
			write_protect_n = rows[i][10];
			area_protected = rows[i][9];
			fl = rows[i][8];
			pf = rows[i][12];
			cmd({rows[i][31:16], 8'hFF}, rows[i][11] ? 2 : 1);
			chk("status_one", {16'h0, rows[i][7:0]}, {16'h0, status_one});
			$display("row %0d done", i);
		end
		chk("nv_write count", 24'd4, 24'(nvw));
		chk("nv_data", 24'h000004, {16'h0, nv_data});
		// status read repeats the byte while selected
		host.frame(24'h05FFFF, 3, rx);
		chk("status bytes", 24'h000606, {8'h0, rx[15:0]});
		chk("miso_oe idle", 24'h000000, {23'h0, miso_oe});
		$display("status read done");
		// software reset
		cmd(24'hF0FFFF, 1);
		chk("status after soft reset", 24'h00001C, {16'h0, status_one});
		$display("soft reset done");
		// suspends during a long program, then during a long erase
		dly = 400;
		cmd(24'h06FFFF, 1);
		cmd(24'h02FFFF, 1);
		chk("status while busy", 24'h00001F, {16'h0, status_one});
		cmd(24'h85FFFF, 1);
		cmd(24'h75FFFF, 1);
		cmd(24'h02FFFF, 1);
		wait_idle();
		chk("status after program", 24'h00001C, {16'h0, status_one});
		cmd(24'h06FFFF, 1);
		cmd(24'hD8FFFF, 1);
		cmd(24'h75FFFF, 1);
		cmd(24'h85FFFF, 1);
		wait_idle();
		chk("suspend pulses", 24'h000101, {8'h0, 8'(sp), 8'(se)});
		chk("op_kind", 24'h000001, {22'h0, op_kind});
		chk("status after erase", 24'h00001C, {16'h0, status_one});
		$display("suspend test done");
		// second reset with non-volatile protect bits
		@(negedge mclk);
		rst = 1'b1;
		protect_volatility_bit = 1'b0;
		nv_status = 8'h88;
		repeat (3) @(negedge mclk);
		chk("status in reset", 24'h000000, {16'h0, status_one});
		rst = 1'b0;
		repeat (3) @(negedge mclk);
		chk("status nonvolatile", 24'h000088, {16'h0, status_one});
		$display("reset test done");
		wrap_up();
	end
endmodule
`default_nettype wire
